// ---- core/dit_bank.v ----
// read-only identity, serial number and sensor trim register bank
`timescale 1ns/1ps
`default_nettype none
`include "dit_defines.vh"

module dit_bank #(
  parameter [11:0] PART_CODE     = 12'ha5a, // value is arbitrary
  parameter [3:0]  REVISION_CODE = 4'h1     // value is arbitrary
) (
  // clock and reset
  input  wire       i_ref_clk,
  input  wire       i_srst,
  // register port
  input  wire [6:0] i_reg_addr,
  input  wire       i_reg_rd,
  input  wire       i_reg_wr,
  input  wire [7:0] i_reg_wdata,
  output reg  [7:0] o_reg_rdata,
  output reg        o_reg_rvalid,
  // factory storage load
  input  wire       i_trim_load,
  input  wire [2:0] i_fab_code,
  input  wire [5:0] i_second_char_field,
  input  wire [5:0] i_third_char_field,
  input  wire [5:0] i_fourth_char_field,
  input  wire [9:0] i_lot_number,
  input  wire [4:0] i_wafer_index,
  input  wire [8:0] i_die_x_coordinate,
  input  wire [8:0] i_die_y_coordinate,
  input  wire       i_serial_parity,
  input  wire [3:0] i_serial_crc,
  input  wire [7:0] i_x_q_deviation,
  input  wire [7:0] i_y_q_deviation,
  input  wire [7:0] i_z_q_deviation,
  input  wire [7:0] i_x_resonance_offset,
  input  wire [7:0] i_y_resonance_offset,
  input  wire [7:0] i_z_resonance_offset,
  // status
  output reg        o_trim_loaded
);

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  reg  [7:0] serial_r      [0:6];
  reg  [7:0] serial_nxt    [0:6];
  reg  [7:0] serial_pack   [0:6];
  reg  [7:0] trim_r        [0:5];
  reg  [7:0] trim_nxt      [0:5];
  reg        loaded_nxt;

  // factory field views
  reg  [2:0] fab_field;
  reg  [6:0] lot_field;
  reg  [4:0] wafer_field;
  reg  [6:0] x_high_field;
  reg  [6:0] y_high_field;
  reg  [2:0] y_low_field;
  reg        second_ok;
  reg        third_ok;
  reg        fourth_ok;
  reg        chars_ok;

  // read path
  wire [7:0] part_high_value;
  wire [7:0] part_low_value;
  reg        take_rd;
  reg        hit_part_high;
  reg        hit_part_low;
  reg        hit_serial;
  reg        hit_trim;
  reg  [2:0] serial_sel;
  reg  [2:0] trim_sel;
  reg  [7:0] rdata_nxt;
  reg  [7:0] out_rdata_nxt;
  reg        rvalid_nxt;

  // --------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------
  // unused character codes are stored as given; software screens them
  function dit_char_ok;
    input [5:0] code;
    begin
      if (code <= `DIT_CHAR_DIGIT_LAST) begin
        dit_char_ok = 1'b1;
      end else if (code <= `DIT_CHAR_ALPHA_LAST) begin
        dit_char_ok = 1'b1;
      end else begin
        dit_char_ok = 1'b0;
      end
    end
  endfunction

  function dit_in_span;
    input [6:0] addr;
    input [6:0] first;
    input [6:0] last;
    begin
      dit_in_span = (addr >= first) && (addr <= last);
    end
  endfunction

  // only the low bits matter inside a span of at most eight bytes
  function [2:0] dit_span_index;
    input [6:0] addr;
    input [6:0] first;
    reg   [6:0] diff;
    begin
      diff           = addr - first;
      dit_span_index = diff[2:0];
    end
  endfunction

  // --------------------------------------------------------------------
  // fixed identity
  // --------------------------------------------------------------------
  assign part_high_value = PART_CODE[11:4];
  assign part_low_value  = {PART_CODE[3:0], REVISION_CODE};

  // --------------------------------------------------------------------
  // factory fields
  // --------------------------------------------------------------------
  // lot bits 9:7 have no room in the serial layout and are dropped
  always @* begin
    fab_field   = i_fab_code;
    lot_field   = i_lot_number[6:0];
    wafer_field = i_wafer_index;
  end

  // x keeps bits 8:2 only; y bit 2 shows in two bytes
  always @* begin
    x_high_field = i_die_x_coordinate[8:2];
    y_high_field = i_die_y_coordinate[8:2];
    y_low_field  = i_die_y_coordinate[2:0];
  end

  // an unused code still loads; the flag is the only warning
  always @* begin
    second_ok = dit_char_ok(i_second_char_field);
    third_ok  = dit_char_ok(i_third_char_field);
    fourth_ok = dit_char_ok(i_fourth_char_field);
    chars_ok  = second_ok & third_ok & fourth_ok;
  end

  // --------------------------------------------------------------------
  // serial packing
  // --------------------------------------------------------------------
  // the three-bit fab code fills bits 7:5 of byte 0; the zero pad bit sits in byte 6
  always @* begin
    serial_pack[0] = {fab_field, i_second_char_field[5:1]};
    serial_pack[1] = {i_second_char_field[0], i_third_char_field,
                      i_fourth_char_field[5]};
    serial_pack[2] = {i_fourth_char_field[4:0],
                      lot_field[6:4]};
    serial_pack[3] = {lot_field[3:0], wafer_field[4:1]};
    serial_pack[4] = {wafer_field[0], x_high_field};
    serial_pack[5] = {y_high_field, i_serial_parity};
    serial_pack[6] = {y_low_field, `DIT_SERIAL6_PAD,
                      i_serial_crc};
  end

  // --------------------------------------------------------------------
  // serial next contents; a load is the only way they change
  // --------------------------------------------------------------------
  always @* begin
    serial_nxt[0] = serial_r[0];
    serial_nxt[1] = serial_r[1];
    serial_nxt[2] = serial_r[2];
    serial_nxt[3] = serial_r[3];
    serial_nxt[4] = serial_r[4];
    serial_nxt[5] = serial_r[5];
    serial_nxt[6] = serial_r[6];
    if (i_trim_load) begin
      serial_nxt[0] = serial_pack[0];
      serial_nxt[1] = serial_pack[1];
      serial_nxt[2] = serial_pack[2];
      serial_nxt[3] = serial_pack[3];
      serial_nxt[4] = serial_pack[4];
      serial_nxt[5] = serial_pack[5];
      serial_nxt[6] = serial_pack[6];
    end
  end

  // --------------------------------------------------------------------
  // sensor trim next contents
  // --------------------------------------------------------------------
  // signed bytes pass untouched; scaling is left to software
  always @* begin
    trim_nxt[0] = trim_r[0];
    trim_nxt[1] = trim_r[1];
    trim_nxt[2] = trim_r[2];
    trim_nxt[3] = trim_r[3];
    trim_nxt[4] = trim_r[4];
    trim_nxt[5] = trim_r[5];
    if (i_trim_load) begin
      trim_nxt[0] = i_x_q_deviation;
      trim_nxt[1] = i_y_q_deviation;
      trim_nxt[2] = i_z_q_deviation;
      trim_nxt[3] = i_x_resonance_offset;
      trim_nxt[4] = i_y_resonance_offset;
      trim_nxt[5] = i_z_resonance_offset;
    end
  end

  // --------------------------------------------------------------------
  // load flag
  // --------------------------------------------------------------------
  always @* begin
    loaded_nxt = o_trim_loaded;
    if (i_trim_load) begin
      loaded_nxt = chars_ok;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_trim_loaded <= `DIT_LOADED_RESET;
    end else begin
      o_trim_loaded <= loaded_nxt;
    end
  end

  // --------------------------------------------------------------------
  // storage registers
  // --------------------------------------------------------------------
  // zero until the first factory load
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      serial_r[0] <= `DIT_SERIAL_RESET;
      serial_r[1] <= `DIT_SERIAL_RESET;
      serial_r[2] <= `DIT_SERIAL_RESET;
      serial_r[3] <= `DIT_SERIAL_RESET;
      serial_r[4] <= `DIT_SERIAL_RESET;
      serial_r[5] <= `DIT_SERIAL_RESET;
      serial_r[6] <= `DIT_SERIAL_RESET;
    end else begin
      serial_r[0] <= serial_nxt[0];
      serial_r[1] <= serial_nxt[1];
      serial_r[2] <= serial_nxt[2];
      serial_r[3] <= serial_nxt[3];
      serial_r[4] <= serial_nxt[4];
      serial_r[5] <= serial_nxt[5];
      serial_r[6] <= serial_nxt[6];
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      trim_r[0] <= `DIT_TRIM_RESET;
      trim_r[1] <= `DIT_TRIM_RESET;
      trim_r[2] <= `DIT_TRIM_RESET;
      trim_r[3] <= `DIT_TRIM_RESET;
      trim_r[4] <= `DIT_TRIM_RESET;
      trim_r[5] <= `DIT_TRIM_RESET;
    end else begin
      trim_r[0] <= trim_nxt[0];
      trim_r[1] <= trim_nxt[1];
      trim_r[2] <= trim_nxt[2];
      trim_r[3] <= trim_nxt[3];
      trim_r[4] <= trim_nxt[4];
      trim_r[5] <= trim_nxt[5];
    end
  end

  // --------------------------------------------------------------------
  // read decode
  // --------------------------------------------------------------------
  // writes take no path into storage; strobe and data stay unread
  always @* begin
    take_rd       = i_reg_rd;
    hit_part_high = (i_reg_addr == `DIT_OFS_PART_HIGH);
    hit_part_low  = (i_reg_addr == `DIT_OFS_PART_LOW);
    hit_serial    = dit_in_span(i_reg_addr, `DIT_OFS_SERIAL_0,
                                `DIT_OFS_SERIAL_6);
    hit_trim      = dit_in_span(i_reg_addr, `DIT_OFS_Q_X, `DIT_OFS_F_Z);
    serial_sel    = dit_span_index(i_reg_addr, `DIT_OFS_SERIAL_0);
    trim_sel      = dit_span_index(i_reg_addr, `DIT_OFS_Q_X);
  end

  // unmapped and reserved offsets read zero
  always @* begin
    rdata_nxt = `DIT_RDATA_UNMAPPED;
    if (hit_part_high) begin
      rdata_nxt = part_high_value;
    end else if (hit_part_low) begin
      rdata_nxt = part_low_value;
    end else if (hit_serial) begin
      rdata_nxt = serial_r[serial_sel];
    end else if (hit_trim) begin
      rdata_nxt = trim_r[trim_sel];
    end
  end

  // --------------------------------------------------------------------
  // read answer
  // --------------------------------------------------------------------
  // data holds between reads so a slow host may sample it late
  always @* begin
    rvalid_nxt    = take_rd;
    out_rdata_nxt = o_reg_rdata;
    if (take_rd) begin
      out_rdata_nxt = rdata_nxt;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rdata <= `DIT_RDATA_RESET;
    end else begin
      o_reg_rdata <= out_rdata_nxt;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rvalid <= `DIT_RVALID_RESET;
    end else begin
      o_reg_rvalid <= rvalid_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- core/dit_defines.vh ----
// register offsets, character code limits and reset values of the identity bank
`ifndef DIT_DEFINES_VH
`define DIT_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define DIT_OFS_PART_HIGH   7'h02
`define DIT_OFS_PART_LOW    7'h03
`define DIT_OFS_SERIAL_0    7'h04
`define DIT_OFS_SERIAL_1    7'h05
`define DIT_OFS_SERIAL_2    7'h06
`define DIT_OFS_SERIAL_3    7'h07
`define DIT_OFS_SERIAL_4    7'h08
`define DIT_OFS_SERIAL_5    7'h09
`define DIT_OFS_SERIAL_6    7'h0a
`define DIT_OFS_Q_X         7'h0b
`define DIT_OFS_Q_Y         7'h0c
`define DIT_OFS_Q_Z         7'h0d
`define DIT_OFS_F_X         7'h0e
`define DIT_OFS_F_Y         7'h0f
`define DIT_OFS_F_Z         7'h10

// ----------------------------------------------------------------------
// reset values and character code limits
// ----------------------------------------------------------------------
`define DIT_SERIAL_RESET    8'h00
`define DIT_TRIM_RESET      8'h00
`define DIT_RDATA_UNMAPPED  8'h00
`define DIT_CHAR_DIGIT_LAST 6'h09
`define DIT_CHAR_ALPHA_LAST 6'h23
`define DIT_SERIAL6_PAD     1'b0
`define DIT_RDATA_RESET     8'h00
`define DIT_RVALID_RESET    1'b0
`define DIT_LOADED_RESET    1'b0

`endif

// ---- testbench/dit_bank_monitor.sv ----
// port assertions of the identity bank
`timescale 1ns/1ps
`default_nettype none
module dit_bank_monitor #(parameter [11:0] PART_CODE = 12'ha5a,
  parameter [3:0] REVISION_CODE = 4'h1) (
  input wire logic       i_ref_clk, i_srst, i_reg_rd, i_trim_load,
  input wire logic       o_reg_rvalid, o_trim_loaded,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read unanswered");
  a_no_spurious: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("spurious rvalid");
  a_part_high: assert property (i_reg_rd && i_reg_addr == 7'h02
    |=> o_reg_rdata == PART_CODE[11:4]) else $error("part high wrong");
  a_part_low: assert property (i_reg_rd && i_reg_addr == 7'h03
    |=> o_reg_rdata == {PART_CODE[3:0], REVISION_CODE})
    else $error("part low wrong");
  a_unmapped_zero: assert property (i_reg_rd && (i_reg_addr < 7'h02
    || i_reg_addr > 7'h10) |=> o_reg_rdata == 8'h00)
    else $error("unmapped not zero");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("rdata moved");
  a_flag_hold: assert property (!i_trim_load |=> $stable(o_trim_loaded))
    else $error("flag moved");
  a_reset_clear: assert property ($fell(i_srst)
    |-> o_reg_rdata == 8'h00 && !o_trim_loaded) else $error("reset state");
endmodule
bind dit_bank dit_bank_monitor #(.PART_CODE(PART_CODE),
  .REVISION_CODE(REVISION_CODE)) mon_u (.i_ref_clk(i_ref_clk),
  .i_srst(i_srst), .i_reg_rd(i_reg_rd), .i_trim_load(i_trim_load),
  .o_reg_rvalid(o_reg_rvalid), .o_trim_loaded(o_trim_loaded),
  .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata));
`default_nettype wire

// ---- testbench/dit_bank_test.sv ----
// self-checking bench of the identity bank
`timescale 1ns/1ps
`default_nettype none
module dit_bank_test;
  logic i_ref_clk = 0, i_srst = 1, i_trim_load = 0, i_serial_parity = 0;
  logic i_reg_rd, i_reg_wr, o_reg_rvalid, o_trim_loaded, go = 0, wgo = 0;
  logic [2:0] i_fab_code = 0;
  logic [3:0] i_serial_crc = 0;
  logic [4:0] i_wafer_index = 1;
  logic [5:0] i_second_char_field = 0, i_third_char_field = 0;
  logic [5:0] i_fourth_char_field = 0;
  logic [6:0] a = 0, i_reg_addr, e, q [$];
  logic [7:0] wd = 0, i_reg_wdata, o_reg_rdata, m [128];
  logic [7:0] i_x_q_deviation = 0, i_y_q_deviation = 0, i_z_q_deviation = 0;
  logic [7:0] i_x_resonance_offset = 0, i_y_resonance_offset = 0;
  logic [7:0] i_z_resonance_offset = 0;
  logic [8:0] i_die_x_coordinate = 0, i_die_y_coordinate = 0;
  logic [9:0] i_lot_number = 0;
  logic [31:0] s = 32'h86ae_9dd4;
  int err_count = 0, num_checks = 0, cyc = 0;
  dit_bank #(.PART_CODE(12'h3c9), .REVISION_CODE(4'h6)) dut_u (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
    .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_trim_load(i_trim_load), .i_fab_code(i_fab_code),
    .i_second_char_field(i_second_char_field),
    .i_third_char_field(i_third_char_field),
    .i_fourth_char_field(i_fourth_char_field),
    .i_lot_number(i_lot_number), .i_wafer_index(i_wafer_index),
    .i_die_x_coordinate(i_die_x_coordinate),
    .i_die_y_coordinate(i_die_y_coordinate),
    .i_serial_parity(i_serial_parity), .i_serial_crc(i_serial_crc),
    .i_x_q_deviation(i_x_q_deviation), .i_y_q_deviation(i_y_q_deviation),
    .i_z_q_deviation(i_z_q_deviation),
    .i_x_resonance_offset(i_x_resonance_offset),
    .i_y_resonance_offset(i_y_resonance_offset),
    .i_z_resonance_offset(i_z_resonance_offset),
    .o_trim_loaded(o_trim_loaded));
  dit_host host_u (.i_ref_clk(i_ref_clk), .i_go(go), .i_wgo(wgo), .i_a(a),
    .i_wd(wd), .o_rd(i_reg_rd), .o_wr(i_reg_wr), .o_addr(i_reg_addr),
    .o_wdata(i_reg_wdata));
  always #5 i_ref_clk = ~i_ref_clk;
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // back-to-back strobes over 0x00..0x12, writes carry random data
  task automatic sweep(input bit w);
    for (int i = 0; i < 19; i++) begin
      @(posedge i_ref_clk);
      {go, wgo} <= {!w, w};
      a <= i[6:0];
      wd <= s[7:0] ^ i[7:0];
    end
    @(posedge i_ref_clk);
    {go, wgo} <= 2'b00;
    repeat (4) @(posedge i_ref_clk);
  endtask
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (o_reg_rvalid) begin
      num_checks++;
      if (q.size() == 0) begin
        $display("mismatch t=%0t unrequested rvalid", $time);
        err_count++;
      end else begin
        e = q.pop_front();
        if (o_reg_rdata !== m[e]) begin
          $display("mismatch t=%0t addr %h got %h", $time, e, o_reg_rdata);
          err_count++;
        end
      end
    end
    if (i_reg_rd) q.push_back(i_reg_addr);
    if (cyc > 3000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    foreach (m[i]) m[i] = 8'h00;
    {m[2], m[3]} = 16'h3c96;
    repeat (12) @(posedge i_ref_clk);
    i_srst <= 0;
    sweep(0);
    for (int k = 0; k < 4; k++) begin
      s = nx(s);
      {i_fab_code, i_lot_number, i_die_x_coordinate,
        i_die_y_coordinate} <= s[30:0];
      i_second_char_field <= s[5:0] % 6'd36;
      i_third_char_field <= s[11:6] % 6'd36;
      // last pass loads an unused code, which must drop the flag
      i_fourth_char_field <= (k == 3) ? 6'h3f : s[17:12] % 6'd36;
      s = nx(s);
      {i_serial_parity, i_serial_crc, i_x_q_deviation, i_y_q_deviation,
        i_z_q_deviation} <= s[28:0];
      i_wafer_index <= (s[31:27] == 0) ? 5'd31 : s[31:27];
      s = nx(s);
      {i_x_resonance_offset, i_y_resonance_offset,
        i_z_resonance_offset} <= s[23:0];
      i_trim_load <= 1;
      @(posedge i_ref_clk);
      i_trim_load <= 0;
      m[4] = {i_fab_code, i_second_char_field[5:1]};
      m[5] = {i_second_char_field[0], i_third_char_field,
        i_fourth_char_field[5]};
      m[6] = {i_fourth_char_field[4:0], i_lot_number[6:4]};
      m[7] = {i_lot_number[3:0], i_wafer_index[4:1]};
      m[8] = {i_wafer_index[0], i_die_x_coordinate[8:2]};
      m[9] = {i_die_y_coordinate[8:2], i_serial_parity};
      m[10] = {i_die_y_coordinate[2:0], 1'b0, i_serial_crc};
      {m[11], m[12], m[13]} = {i_x_q_deviation, i_y_q_deviation,
        i_z_q_deviation};
      {m[14], m[15], m[16]} = {i_x_resonance_offset, i_y_resonance_offset,
        i_z_resonance_offset};
      sweep(1);
      sweep(0);
      num_checks++;
      if (o_trim_loaded !== (k != 3)) begin
        $display("mismatch t=%0t char flag %b", $time, o_trim_loaded);
        err_count++;
      end
    end
    summarize();
  end
endmodule
`default_nettype wire

// ---- testbench/dit_host.sv ----
// host model issuing register strobes
`timescale 1ns/1ps
`default_nettype none
module dit_host (
  input  wire logic       i_ref_clk, i_go, i_wgo,
  input  wire logic [6:0] i_a,
  input  wire logic [7:0] i_wd,
  output var  logic       o_rd = 0, o_wr = 0,
  output var  logic [6:0] o_addr = 0,
  output var  logic [7:0] o_wdata = 0
);
  // idle address toggles so a stale one never looks valid
  always @(posedge i_ref_clk) begin
    o_rd <= i_go;
    o_wr <= i_wgo;
    o_wdata <= i_wd;
    o_addr <= (i_go | i_wgo) ? i_a : ~o_addr;
  end
endmodule
`default_nettype wire
